// ===== trigger_line_drive_and_read.sv
// Trigger line drive source selector and line level reader
`timescale 1ns/1ps
`include "trig_map.svh"
module trigger_line_drive_and_read #(
  parameter int NUM_LINES = `TRIG_NUM_LINES
) (
  input  wire logic                   sys_clk,
  input  wire logic                   arst_n,
  input  wire logic                   clk_en,
  input  wire trig_pkg::drive_cfg_t   drive_cfg,
  input  wire trig_pkg::status_t      acq_status,
  input  wire logic [3:0]             read_line,
  input  wire logic                   in_pol,
  input  wire logic [NUM_LINES-1:0]   trig_in,
  output logic      [NUM_LINES-1:0]   trig_out,
  output logic      [NUM_LINES-1:0]   trig_oe,
  output logic                        trig_status
);

  // Timing, counted in enabled edges:
  //   a write taken on edge n updates the store on edge n
  //   enable and pin level of that line follow on edge n + 1
  //   a change of a status source shows one edge later
  //   a pin change reaches the read-back three edges later
  // Clock enable low freezes every register, synchroniser included.

  // Index map: external lines first, then the sync bus lines
  localparam int EXT_LINES  = `TRIG_EXT_LINES;
  localparam int SYNC_FIRST = `TRIG_SYNC_FIRST;
  localparam int SYNC_LINES = NUM_LINES - EXT_LINES;

  // Per-line drive configuration, cleared by reset
  trig_pkg::drive_src_t src_q [NUM_LINES];
  logic [NUM_LINES-1:0] pol_q;

  // Line level synchroniser stages
  logic [NUM_LINES-1:0] meta_q;
  logic [NUM_LINES-1:0] sync_q;

  // Write data and one-hot write strobes
  trig_pkg::drive_src_t wr_src;
  logic                 wr_pol;
  logic [NUM_LINES-1:0] wr_hit;

  // Next values of the registered outputs
  logic [NUM_LINES-1:0] lvl_d;
  logic [NUM_LINES-1:0] oe_d;
  logic [NUM_LINES-1:0] out_d;
  logic [NUM_LINES-1:0] rd_adj;
  logic                 status_d;

  // True when an index names one of the trigger lines
  function automatic logic line_ok(
    input logic [3:0] idx
  );
    logic ok;

    ok = 1'b0;
    if (idx < 4'(EXT_LINES)) begin
      ok = 1'b1;
    end
    if (idx >= 4'(SYNC_FIRST) && idx < 4'(SYNC_FIRST + SYNC_LINES)) begin
      ok = 1'b1;
    end
    return ok;
  endfunction

  // True when a source code puts a level on the line
  function automatic logic src_drives(
    input trig_pkg::drive_src_t s
  );
    logic d;

    d = 1'b1;
    if (s == `TRIG_SRC_DISABLED) begin
      d = 1'b0;
    end
    return d;
  endfunction

  // Logical (polarity-free) level of a source; every source is a level,
  // so an edge-like source lasts as long as its status input does
  function automatic logic src_level(
    input trig_pkg::drive_src_t s,
    input trig_pkg::status_t    st
  );
    logic v;

    v = 1'b0;
    unique case (s)
      `TRIG_SRC_DISABLED: begin
        v = 1'b0;
      end
      // Acquisition state
      `TRIG_SRC_ACQ_RUN: begin
        v = st.acq_running;
      end
      `TRIG_SRC_ACQ_DONE: begin
        v = st.acq_done;
      end
      // Static levels
      `TRIG_SRC_UNASSERT: begin
        v = 1'b0;
      end
      `TRIG_SRC_ASSERT: begin
        v = 1'b1;
      end
      // Camera timing
      `TRIG_SRC_HSYNC: begin
        v = st.hsync;
      end
      `TRIG_SRC_VSYNC: begin
        v = st.vsync;
      end
      // Frame timing, meaningless in line scan
      `TRIG_SRC_FRM_START: begin
        v = st.frame_active;
      end
      `TRIG_SRC_FRM_DONE: begin
        v = st.frame_done;
      end
      default: begin
        // Codes above the last source drive the unasserted level
        v = 1'b0;
      end
    endcase
    return v;
  endfunction

  // Pin level of a logical level; the same map serves both directions
  function automatic logic apply_pol(
    input logic lvl,
    input logic pol
  );
    logic r;

    r = lvl ~^ pol;
    return r;
  endfunction

  // Level of one line picked out of a vector by its index
  function automatic logic pick_line(
    input logic [NUM_LINES-1:0] v,
    input logic [3:0]           idx
  );
    logic b;

    b = 1'b0;
    for (int i = 0; i < NUM_LINES; i++) begin
      if (idx == 4'(i)) begin
        b = v[i];
      end
    end
    return b;
  endfunction

  // Write data, parked at safe values while no write is taken
  always_comb begin
    wr_src = `TRIG_SRC_DISABLED;
    wr_pol = 1'b0;
    if (clk_en && drive_cfg.src_we) begin
      wr_src = drive_cfg.src;
      wr_pol = drive_cfg.out_pol;
    end
  end

  // One-hot write strobe; a refused index decodes to nothing
  always_comb begin
    wr_hit = '0;
    if (clk_en && drive_cfg.src_we) begin
      if (line_ok(drive_cfg.line)) begin
        for (int i = 0; i < NUM_LINES; i++) begin
          if (drive_cfg.line == 4'(i)) begin
            wr_hit[i] = 1'b1;
          end
        end
      end
    end
  end

  // Source selection store; only the addressed line changes,
  // so writes to different lines may come back to back
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < NUM_LINES; i++) begin
        src_q[i] <= `TRIG_SRC_DISABLED;
      end
    end else begin
      for (int i = 0; i < NUM_LINES; i++) begin
        if (wr_hit[i]) begin
          src_q[i] <= wr_src;
        end
      end
    end
  end

  // Output polarity store, written together with the source
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < NUM_LINES; i++) begin
        pol_q[i] <= 1'b0;
      end
    end else begin
      for (int i = 0; i < NUM_LINES; i++) begin
        if (wr_hit[i]) begin
          pol_q[i] <= wr_pol;
        end
      end
    end
  end

  // Logical level of each line's source
  always_comb begin
    lvl_d = '0;
    for (int i = 0; i < NUM_LINES; i++) begin
      lvl_d[i] = src_level(src_q[i], acq_status);
    end
  end

  // Enable and pin level of each line; an idle line is parked low
  // so that its pin value never toggles behind a released driver
  always_comb begin
    oe_d  = '0;
    out_d = '0;
    for (int i = 0; i < NUM_LINES; i++) begin
      oe_d[i] = src_drives(src_q[i]);
      if (oe_d[i]) begin
        out_d[i] = apply_pol(lvl_d[i], pol_q[i]);
      end else begin
        out_d[i] = 1'b0;
      end
    end
  end

  // Output enables
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < NUM_LINES; i++) begin
        trig_oe[i] <= 1'b0;
      end
    end else if (clk_en) begin
      for (int i = 0; i < NUM_LINES; i++) begin
        trig_oe[i] <= oe_d[i];
      end
    end
  end

  // Output levels
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < NUM_LINES; i++) begin
        trig_out[i] <= 1'b0;
      end
    end else if (clk_en) begin
      for (int i = 0; i < NUM_LINES; i++) begin
        trig_out[i] <= out_d[i];
      end
    end
  end

  // First synchroniser stage; only the second stage reads it
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < NUM_LINES; i++) begin
        meta_q[i] <= 1'b0;
      end
    end else if (clk_en) begin
      for (int i = 0; i < NUM_LINES; i++) begin
        meta_q[i] <= trig_in[i];
      end
    end
  end

  // Second synchroniser stage
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < NUM_LINES; i++) begin
        sync_q[i] <= 1'b0;
      end
    end else if (clk_en) begin
      for (int i = 0; i < NUM_LINES; i++) begin
        sync_q[i] <= meta_q[i];
      end
    end
  end

  // Polarity-adjusted level of every line
  always_comb begin
    rd_adj = '0;
    for (int i = 0; i < NUM_LINES; i++) begin
      rd_adj[i] = apply_pol(sync_q[i], in_pol);
    end
  end

  // Read-back selection; an index past the last line reads zero
  always_comb begin
    status_d = 1'b0;
    if (line_ok(read_line)) begin
      status_d = pick_line(rd_adj, read_line);
    end
  end

  // Line status read-back
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      trig_status <= 1'b0;
    end else if (clk_en) begin
      trig_status <= status_d;
    end
  end

endmodule

// ===== trig_map.svh
// Constants for the trigger line drive and read block
`ifndef TRIG_MAP_SVH
`define TRIG_MAP_SVH
`define TRIG_EXT_LINES     4
`define TRIG_SYNC_LINES    7
`define TRIG_NUM_LINES     11
`define TRIG_SEL_W         4
`define TRIG_SRC_W         4
`define TRIG_SRC_DISABLED  4'h0
`define TRIG_SRC_ACQ_RUN   4'h1
`define TRIG_SRC_ACQ_DONE  4'h2
`define TRIG_SRC_UNASSERT  4'h3
`define TRIG_SRC_ASSERT    4'h4
`define TRIG_SRC_HSYNC     4'h5
`define TRIG_SRC_VSYNC     4'h6
`define TRIG_SRC_FRM_START 4'h7
`define TRIG_SRC_FRM_DONE  4'h8
`define TRIG_SYNC_FIRST    4'h4
`endif

// ===== trig_pkg.sv
// Types for the trigger line drive and read block
package trig_pkg;
  typedef logic [3:0] drive_src_t;
  typedef struct packed {
    logic acq_running;
    logic acq_done;
    logic hsync;
    logic vsync;
    logic frame_active;
    logic frame_done;
  } status_t;
  typedef struct packed {
    logic [3:0] line;
    logic       src_we;
    drive_src_t src;
    logic       out_pol;
  } drive_cfg_t;
endpackage

// ===== trig_asserts.sv
// Port checker for the trigger line block
`timescale 1ns/1ps
module trig_chk #(parameter int NUM_LINES = 11) (
  input logic                 sys_clk,
  input logic                 arst_n,
  input logic                 clk_en,
  input trig_pkg::drive_cfg_t drive_cfg,
  input trig_pkg::status_t    acq_status,
  input logic [3:0]           read_line,
  input logic                 in_pol,
  input logic [NUM_LINES-1:0] trig_in,
  input logic [NUM_LINES-1:0] trig_out,
  input logic [NUM_LINES-1:0] trig_oe,
  input logic                 trig_status
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  wire [3:0] l = drive_cfg.line;
  wire [3:0] s = drive_cfg.src;
  wire p = drive_cfg.out_pol;
  wire we = clk_en & drive_cfg.src_we;
  wire w = we & (l < 4'hB);
  wire rd = trig_in[read_line];
  logic [2:0] n_q;
  always_ff @(posedge sys_clk or negedge arst_n)
    if (!arst_n) n_q <= 3'h0;
    else if (n_q != 3'h7) n_q <= n_q + 3'h1;
  wire g = (n_q == 3'h7) & clk_en & (read_line < 4'hB);
  // Logical level each source code should give, unknown codes unasserted
  function automatic logic want(logic [3:0] c, trig_pkg::status_t t);
    case (c)
      4'h1: return t.acq_running;
      4'h2: return t.acq_done;
      4'h4: return 1'b1;
      4'h5: return t.hsync;
      4'h6: return t.vsync;
      4'h7: return t.frame_active;
      4'h8: return t.frame_done;
      default: return 1'b0;
    endcase
  endfunction
  a_rst_idle: assert property (n_q < 3'h2 |->
    trig_oe == '0) else $error("driven after reset");
  a_dis_off: assert property (w && s == 4'h0 ##1 clk_en |-> ##1
    !trig_oe[$past(l,2)]) else $error("disabled line driven");
  a_set_on: assert property (w && s == 4'h4 ##1 clk_en |-> ##1
    trig_out[$past(l,2)] == $past(p,2)) else $error("asserted level");
  a_set_off: assert property (w && s == 4'h3 ##1 clk_en |-> ##1
    trig_oe[$past(l,2)] && trig_out[$past(l,2)] != $past(p,2))
    else $error("unasserted level");
  a_run_src: assert property (w && s == 4'h1 ##1 clk_en && !w
    ##1 clk_en |-> ##1
    trig_out[$past(l,3)] == ($past(acq_status.acq_running) ~^ $past(p,3)))
    else $error("running source");
  a_vsync_src: assert property (w && s == 4'h6 ##1 clk_en && !w
    ##1 clk_en |-> ##1
    trig_out[$past(l,3)] == ($past(acq_status.vsync) ~^ $past(p,3)))
    else $error("vsync source");
  a_src_map: assert property (w ##1 clk_en && !w
    ##1 clk_en |-> ##1
    trig_oe[$past(l,3)] == ($past(s,3) != 4'h0) && ($past(s,3) == 4'h0 ||
      trig_out[$past(l,3)] ==
      (want($past(s,3), $past(acq_status)) ~^ $past(p,3))))
    else $error("source map");
  a_bad_read: assert property (clk_en && read_line > 4'hA |-> ##1
    trig_status == 1'b0) else $error("refused read");
  a_bad_line: assert property (we && l > 4'hA |-> ##2
    $stable(trig_oe)) else $error("refused write took effect");
  a_read_lvl: assert property ((g && $stable({read_line,in_pol}))[*4] |->
    trig_status == ($past(rd,3) ~^ in_pol)) else $error("read level");
endmodule
bind trigger_line_drive_and_read trig_chk #(.NUM_LINES(NUM_LINES)) chk (
  .sys_clk(sys_clk), .arst_n(arst_n), .clk_en(clk_en),
  .drive_cfg(drive_cfg), .acq_status(acq_status), .read_line(read_line),
  .in_pol(in_pol), .trig_in(trig_in), .trig_out(trig_out),
  .trig_oe(trig_oe), .trig_status(trig_status));

// ===== trig_far.sv
// Other boards sharing the trigger lines
`timescale 1ns/1ps
module trig_far (
  input  logic        sys_clk,
  input  logic [10:0] oe,
  input  logic [10:0] drv,
  output logic [10:0] lvl
);
  logic [10:0] far_q = 11'h000;
  // Undriven lines wander every cycle so a stale level is never trusted
  always @(negedge sys_clk) far_q <= 11'($urandom);
  assign lvl = (oe & drv) | (~oe & far_q);
endmodule

// ===== tb_top.sv
// Random and corner stimulus for the trigger line block
`timescale 1ns/1ps
module tb_top;
  logic sys_clk = 0, arst_n = 0, clk_en = 1, in_pol = 0, ts, p, v;
  logic [3:0] rl = 4'h0, l, s;
  logic [10:0] tin, tout, toe;
  trig_pkg::drive_cfg_t cfg = '0;
  trig_pkg::status_t st = '0;
  int err_total = 0, tests_run = 0;
  trigger_line_drive_and_read dut (.sys_clk(sys_clk), .arst_n(arst_n),
    .clk_en(clk_en), .drive_cfg(cfg), .acq_status(st), .read_line(rl),
    .in_pol(in_pol), .trig_in(tin), .trig_out(tout), .trig_oe(toe),
    .trig_status(ts));
  trig_far far (.sys_clk(sys_clk), .oe(toe), .drv(tout), .lvl(tin));
  initial forever #12.5 sys_clk = ~sys_clk;
  function logic lvl_of(logic [3:0] c, logic q);
    return (c == 4'h4) ? q : !q;
  endfunction
  function logic lvl_st(logic [3:0] c, trig_pkg::status_t t);
    case (c)
      4'h1: return t.acq_running;
      4'h2: return t.acq_done;
      4'h4: return 1'b1;
      4'h5: return t.hsync;
      4'h6: return t.vsync;
      4'h7: return t.frame_active;
      4'h8: return t.frame_done;
      default: return 1'b0;
    endcase
  endfunction
  task chk(logic [1:0] got, logic [1:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("Error t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task test_done;
    $display("checks %0d errors %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    void'($urandom(27));
    repeat (8) @(negedge sys_clk);
    arst_n = 1;
    for (int i = 0; i < 60; i++) begin
      l = (i < 2) ? 4'hA * 4'(i) : 4'($urandom_range(15));
      s = (i < 4) ? 4'h3 + 4'(i % 2) : 4'($urandom_range(15));
      p = 1'($urandom);
      clk_en = 1'($urandom);
      st = 6'($urandom);
      @(negedge sys_clk);
      clk_en = 1;
      cfg = '{l, 1'b1, s, p};
      rl = l;
      in_pol = 1'($urandom);
      @(negedge sys_clk);
      cfg.src_we = 0;
      repeat (5) @(negedge sys_clk);
      v = lvl_of(s, p);
      if (l < 4'hB && (s == 4'h0 || s > 4'h2 && s < 4'h5)) begin
        chk(toe[l], s != 4'h0);
        if (s != 4'h0) chk({tout[l], ts}, {v, v ~^ in_pol});
      end
      if (l < 4'hB && s != 4'h0)
        chk({toe[l], tout[l]}, {1'b1, lvl_st(s, st) ~^ p});
      if (l > 4'hA) chk(ts, 1'b0);
      $display("test %0d done", i);
    end
    test_done();
  end
endmodule
